// *** odfp_frame_port.sv ***
// note: pins are sampled by ref_clk, so each pin level must last 2+ clocks
module odfp_frame_port
    import odfp_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // serial pins
    input wire logic sclk_pin,
    input wire logic sync_n_pin,
    input wire logic sdi_pin,
    output logic sdo_pin,
    // converter core side
    output odfp_update_t update_q,
    output logic [15:0] applied_word_q
);

    // positions of the pins inside the synchroniser bank
    localparam int PIN_SCLK = 0;
    localparam int PIN_SYNC = 1;
    localparam int PIN_SDI = 2;
    localparam int PIN_N = 3;

    // top bit of the input shift register
    localparam int WORD_TOP = ODFP_WORD_W - 1;

    // count at which the edge counter stops
    localparam logic [ODFP_CNT_W-1:0] CNT_SAT = ODFP_CNT_FULL + ODFP_CNT_ONE;

    // level loaded into each pin's flops at reset: high for sync, low for sclk and sdi
    localparam logic [PIN_N-1:0] PIN_IDLE = {
        ODFP_SCLK_RST[0],
        ODFP_SYNC_RST[0],
        ODFP_SCLK_RST[0]
    };

    // pin bank
    logic [PIN_N-1:0] pin_raw;
    logic [PIN_N-1:0] pin_lvl;
    logic [PIN_N-1:0] pin_fall;
    logic [PIN_N-1:0] pin_rise;

    // decoded pin events
    logic sclk_fall;
    logic sync_fall;
    logic sync_rise;
    logic sdi_lvl;

    // frame qualifiers
    logic frame_open;
    logic take_bit;
    logic cnt_full;
    logic commit;

    // frame registers
    odfp_state_t state_q;
    logic [ODFP_WORD_W-1:0] shift_q;
    logic [ODFP_CNT_W-1:0] cnt_q;
    logic chain_q;

    // gather the asynchronous pins so one loop serves them all
    assign pin_raw = {sdi_pin, sync_n_pin, sclk_pin};

    // one synchroniser and edge finder per pin
    genvar g;
    generate
        for (g = 0; g < PIN_N; g++) begin : g_pin
            logic s1_q;
            logic s2_q;
            logic s3_q;
            logic lvl_q;
            logic agree;

            // three-stage synchroniser; only stage two reads stage one
            always_ff @(posedge ref_clk or negedge nrst) begin
                if (!nrst) begin
                    s1_q <= PIN_IDLE[g];
                    s2_q <= PIN_IDLE[g];
                    s3_q <= PIN_IDLE[g];
                end else begin
                    s1_q <= pin_raw[g];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                end
            end

            // a change counts once stages two and three agree
            assign agree = (s2_q == s3_q);

            // filtered level, starts at the reset level of the pin
            always_ff @(posedge ref_clk or negedge nrst) begin
                if (!nrst) begin
                    lvl_q <= PIN_IDLE[g];
                end else if (agree) begin
                    lvl_q <= s3_q;
                end
            end

            // edges of the filtered level, one clock wide
            assign pin_lvl[g] = lvl_q;
            assign pin_fall[g] = lvl_q && agree && !s3_q;
            assign pin_rise[g] = !lvl_q && agree && s3_q;
        end
    endgenerate

    // pin events by name
    assign sclk_fall = pin_fall[PIN_SCLK];
    assign sync_fall = pin_fall[PIN_SYNC];
    assign sync_rise = pin_rise[PIN_SYNC];
    assign sdi_lvl = pin_lvl[PIN_SDI];

    // frame qualifiers shared by the processes below
    assign frame_open = (state_q == ODFP_SHIFT);
    assign take_bit = frame_open && sclk_fall;
    assign cnt_full = (cnt_q >= ODFP_CNT_FULL);
    assign commit = frame_open && sync_rise && cnt_full;

    // frame state: open on sync fall, close on sync rise
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= ODFP_IDLE;
        end else begin
            case (state_q)
                ODFP_IDLE: begin
                    if (sync_fall) begin
                        state_q <= ODFP_SHIFT;
                    end
                end
                ODFP_SHIFT: begin
                    if (sync_rise) begin
                        state_q <= ODFP_IDLE;
                    end
                end
                default: begin
                    state_q <= ODFP_IDLE;
                end
            endcase
        end
    end

    // falling edge count, saturating so long frames never wrap
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= ODFP_CNT_ZERO;
        end else if (sync_fall) begin
            cnt_q <= ODFP_CNT_ZERO;
        end else if (take_bit && cnt_q != CNT_SAT) begin
            cnt_q <= cnt_q + ODFP_CNT_ONE;
        end
    end

    // input shift register, msb first
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            shift_q <= ODFP_WORD_RST;
        end else if (take_bit) begin
            shift_q <= {shift_q[WORD_TOP-1:0], sdi_lvl};
        end
    end

    // chain output: bit leaving the register, once past 16 edges
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            chain_q <= 1'b0;
        end else if (take_bit && cnt_full) begin
            chain_q <= shift_q[WORD_TOP];
        end else if (!frame_open) begin
            chain_q <= 1'b0;
        end
    end

    // chain pin straight from its flop
    assign sdo_pin = chain_q;

    // update pulse; an early rise leaves everything as it was
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            update_q <= '0;
        end else if (commit) begin
            update_q <= '{valid: 1'b1, word: shift_q};
        end else begin
            update_q.valid <= 1'b0;
        end
    end

    // applied word: zero from reset until the first complete frame
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            applied_word_q <= ODFP_WORD_RST;
        end else if (commit) begin
            applied_word_q <= shift_q;
        end
    end

endmodule : odfp_frame_port

// *** odfp_frame_port_assertions.sv ***
module odfp_frame_port_assertions
    import odfp_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // pins
    input wire logic sclk_pin,
    input wire logic sync_n_pin,
    input wire logic sdi_pin,
    input wire logic sdo_pin,
    // converter side
    input wire odfp_update_t update_q,
    input wire logic [15:0] applied_word_q
);
    // one domain for all checks
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    property p_pulse; update_q.valid |=> !update_q.valid; endproperty
    a_pulse: assert property (p_pulse) else $error("long valid");
    property p_apply;
        update_q.valid |-> ##[0:1] applied_word_q == update_q.word;
    endproperty
    a_apply: assert property (p_apply) else $error("no apply");
    property p_frame;
        update_q.valid |-> sync_n_pin && !$past(sync_n_pin, 8);
    endproperty
    a_frame: assert property (p_frame) else $error("no frame");
    property p_hold;
        $changed(applied_word_q) |-> update_q.valid || $past(update_q.valid);
    endproperty
    a_hold: assert property (p_hold) else $error("stray change");
    property p_word; $changed(update_q.word) |-> update_q.valid; endproperty
    a_word: assert property (p_word) else $error("stray word");
    property p_idle; sync_n_pin [*8] |-> !sdo_pin; endproperty
    a_idle: assert property (p_idle) else $error("idle sdo");
    property p_rise; $rose(sdo_pin) |-> !sync_n_pin; endproperty
    a_rise: assert property (p_rise) else $error("sdo out of frame");
    property p_zero;
        $rose(nrst) |-> applied_word_q == 16'h0000 && !sdo_pin;
    endproperty
    a_zero: assert property (p_zero) else $error("not zero");
    // main scenarios
    cover property (update_q.valid);
    cover property ($rose(sdo_pin));
    cover property ($fell(sync_n_pin));
endmodule : odfp_frame_port_assertions
bind odfp_frame_port odfp_frame_port_assertions odfp_frame_port_assertions_i(
    .ref_clk(ref_clk), .nrst(nrst), .sclk_pin(sclk_pin), .sdi_pin(sdi_pin),
    .sync_n_pin(sync_n_pin), .sdo_pin(sdo_pin), .update_q(update_q),
    .applied_word_q(applied_word_q));

// *** odfp_frame_port_bench.sv ***
module odfp_frame_port_bench;
    import odfp_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    `define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin mismatches++; \
        $display("unexpected %s exp %h got %h", n, e, s); end end
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    wire sclk, sync_n, sdi, sdo;
    odfp_update_t upd;
    logic [15:0] app;
    logic [31:0] seen;
    int mismatches = 0;
    int n_tests = 0;
    int n_upd = 0;
    odfp_host_model odfp_host_model_i(.sclk(sclk), .sync_n(sync_n),
        .sdi(sdi));
    odfp_frame_port odfp_frame_port_i(.ref_clk(ref_clk), .nrst(nrst),
        .sclk_pin(sclk), .sync_n_pin(sync_n), .sdi_pin(sdi), .sdo_pin(sdo),
        .update_q(upd), .applied_word_q(app));
    // clock, update counter, downstream view of the chain output
    initial forever #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (upd.valid === 1'b1) n_upd++;
    always @(negedge sclk or posedge sync_n)
        seen = {seen[30:0], sdo};
    task give_verdict;
        $display("mismatches %0d tests %0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : give_verdict
    task t_reset;
        @(negedge ref_clk);
        nrst = 1'b0;
        repeat (6) @(negedge ref_clk);
        `CHK("sdo", 1'b0, sdo)
        nrst = 1'b1;
        repeat (4) @(negedge ref_clk);
        `CHK("applied", 16'h0000, app)
    endtask : t_reset
    task t_write;
        odfp_host_model_i.send(32'h0000A5C3, 16);
        `CHK("applied", 16'hA5C3, app)
        `CHK("updates", 1, n_upd)
    endtask : t_write
    task t_abort;
        for (int n = 14; n < 16; n++) odfp_host_model_i.send(32'h00001234, n);
        `CHK("applied", 16'hA5C3, app)
        `CHK("updates", 1, n_upd)
    endtask : t_abort
    task t_chain;
        odfp_host_model_i.send(32'h9A5C3E17, 32);
        `CHK("chain", 32'h00009A5C, seen)
        `CHK("applied", 16'h3E17, app)
        `CHK("updates", 2, n_upd)
    endtask : t_chain
    // watchdog and main sequence
    initial begin
        #50000 mismatches++;
        give_verdict;
    end
    initial begin
        t_reset;
        t_write;
        t_abort;
        t_chain;
        t_reset;
        give_verdict;
    end
endmodule : odfp_frame_port_bench

// *** odfp_host_model.sv ***
module odfp_host_model(
    // serial pins toward the device
    output logic sclk = 1'b1,
    output logic sync_n = 1'b1,
    output logic sdi = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    // frame of n bits, msb first, clock idles high
    task automatic send(input logic [31:0] w, input int n);
        sync_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            sdi = w[i];
            #80 sclk = 1'b0;
            #80 sclk = 1'b1;
        end
        #80 sync_n = 1'b1;
        sdi = ~sdi; // released line shows no stale bit
        #400;
    endtask : send
endmodule : odfp_host_model

// *** odfp_pkg.sv ***
package odfp_pkg;
    // frame geometry
    localparam int ODFP_WORD_W = 16;
    localparam int ODFP_CNT_W = 5;
    localparam logic [4:0] ODFP_CNT_FULL = 5'h10;
    localparam logic [4:0] ODFP_CNT_ABORT = 5'h0F;
    localparam logic [4:0] ODFP_CNT_ZERO = 5'h00;
    localparam logic [4:0] ODFP_CNT_ONE = 5'h01;
    localparam logic [15:0] ODFP_WORD_RST = 16'h0000;
    localparam logic [2:0] ODFP_SYNC_RST = 3'h7;
    localparam logic [2:0] ODFP_SCLK_RST = 3'h0;

    // frame state
    typedef enum logic [1:0] {
        ODFP_IDLE = 2'b00,
        ODFP_SHIFT = 2'b01
    } odfp_state_t;

    // applied update carried to the converter core
    typedef struct packed {
        logic valid;
        logic [15:0] word;
    } odfp_update_t;
endpackage : odfp_pkg
